// File: src/bpc_pkg.sv
// Package with register map, field layout and carrier types for board power control
package bpc_pkg;

  // Byte addresses on the register bus
  localparam logic [31:0] ADDR_POWER_CONFIG  = 32'h1200_0000;
  localparam logic [31:0] ADDR_MODEL_CODE    = 32'h2200_0000;
  localparam logic [31:0] ADDR_OPTION_FLAGS  = 32'h2200_0004;

  // Field positions of the power and configuration register
  localparam int unsigned BIT_SERIAL_PWR  = 0;
  localparam int unsigned BIT_USB_PWR     = 1;
  localparam int unsigned BIT_LCD_PWR     = 2;
  localparam int unsigned BIT_SWITCHER_EN = 3;
  localparam int unsigned BIT_XBUS_CLK_OFF = 4;
  localparam int unsigned BIT_FAST_STROBE = 5;
  localparam int unsigned BIT_TTL_ROUTE   = 6;
  localparam int unsigned BIT_SCRATCH     = 7;

  // Reset values and fixed constants
  localparam logic [7:0] POWER_CONFIG_RESET = 8'h00;
  localparam logic       SCRATCH_POR_VALUE  = 1'b0;
  localparam logic [2:0] MODEL_CODE_DEFAULT = 3'h5;
  localparam logic [1:0] TTL_PIN_COUNT      = 2'h2;

  // Sequencer phases run after each board reset release
  typedef enum logic [1:0] {
    BPC_PH_RESET  = 2'b00,
    BPC_PH_STRAP  = 2'b01,
    BPC_PH_RUN    = 2'b10
  } bpc_phase_type;

  // Supply and bus controls driven out of the block
  typedef struct packed {
    logic serial_pwr_on;
    logic usb_pwr_on;
    logic lcd_pwr_on;
    logic switcher_on;
    logic xbus_clk_stop;
    logic fast_strobe;
    logic ttl_route;
  } bpc_ctrl_type;

  // Two header pins shared between digital IO and serial
  typedef struct packed {
    logic [1:0] out;
    logic [1:0] oe_n;
  } bpc_pins_type;

endpackage

// File: src/bpc_pin_mux.sv
// Pin multiplexer giving the serial port precedence over digital IO settings
`timescale 1ns/1ns
module bpc_pin_mux
(
  input  wire logic                  ttl_route,    // Serial owns the pins
  input  wire logic [1:0]            dio_out,      // Digital IO data
  input  wire logic [1:0]            dio_oe_n,     // Digital IO enables
  input  wire logic                  uart_tx,      // Serial transmit
  input  wire logic                  rs232_rx,     // Level-converter receive
  input  wire logic [1:0]            pin_in,       // Header pin levels
  output bpc_pkg::bpc_pins_type      pins,         // Header pin drive
  output logic                       uart_rx,      // Receive to serial
  output logic                       rs232_tx,     // Transmit to converter
  output logic [1:0]                 dio_in        // Pin levels to digital IO
);

  // While routed, pin 0 carries transmit, pin 1 receives, so pin 1 is not driven
  always_comb
  begin
    if (ttl_route)                                        // RQ9
    begin
      pins.out  = {1'b0, uart_tx};                        // RQ10
      pins.oe_n = 2'b10;                                  // RQ10
      uart_rx   = pin_in[1];                              // RQ9
      rs232_tx  = 1'b1;                                   // RQ9
    end
    else
    begin
      pins.out  = dio_out;
      pins.oe_n = dio_oe_n;
      uart_rx   = rs232_rx;
      rs232_tx  = uart_tx;
    end
    dio_in = pin_in;
  end

endmodule

// File: src/bpc_regs.sv
// Board power, configuration and identification registers on Wishbone
//
// Overview of operation
// RQ1: An 8-bit read-write power and configuration register sits at 0x1200_0000.
// RQ2: Bits 0 to 2 switch serial converter, USB and LCD supplies on when set.
// RQ3: Bit 3 enables the 5V switcher and takes writes only with the strap absent.
// RQ4: Bit 3 comes up one with the strap absent and zero with it installed.
// RQ5: Software should leave the switcher enable alone in normal operation.
// RQ6: Bit 4 stops the expansion-bus clock when set.
// RQ7: Bit 5 selects fast non-standard expansion strobes when set.
// RQ8: Software keeps the fast strobe bit clear with ordinary expansion boards.
// RQ9: Bit 6 routes the third serial port to two header pins as TTL.
// RQ10: While routed, the serial port overrides digital IO settings on those pins.
// RQ11: Bit 7 is a scratch bit that keeps its value across board resets.
// RQ12: Watchdog software sets the scratch bit to mark a watchdog restart.
// RQ13: A model register returns a fixed board code in its low three bits.
// RQ14: Options bit 0 reads one with five-UART fitted, zero with extended IO.
// RQ15: Model and options registers are read-only and reads have no side effect.
// RQ16: Only a true power-on clears the scratch bit to zero.
`timescale 1ns/1ns
module bpc_regs
#(
  parameter logic [2:0] MODEL_CODE = bpc_pkg::MODEL_CODE_DEFAULT // Arbitrary
)
(
  input  wire logic                  clk_sys,      // 50 MHz bus clock
  input  wire logic                  rst,          // Board reset, async high
  input  wire logic                  por,          // Power-on reset, async high
  input  wire logic                  switcher_strap_jumper, // Strap installed
  input  wire logic                  five_uart_option,      // Option fitted
  input  wire logic                  wb_cyc_i,     // Wishbone cycle
  input  wire logic                  wb_stb_i,     // Wishbone strobe
  input  wire logic                  wb_we_i,      // Wishbone write
  input  wire logic [31:0]           wb_adr_i,     // Wishbone byte address
  input  wire logic [3:0]            wb_sel_i,     // Wishbone byte lanes
  input  wire logic [31:0]           wb_dat_i,     // Wishbone write data
  output logic [31:0]                wb_dat_o,     // Wishbone read data
  output logic                       wb_ack_o,     // Wishbone acknowledge
  output logic                       wb_err_o,     // Unmapped address
  output bpc_pkg::bpc_ctrl_type      ctrl,         // Supply and bus controls
  input  wire logic [1:0]            dio_out,      // Digital IO data
  input  wire logic [1:0]            dio_oe_n,     // Digital IO enables
  input  wire logic                  uart_tx,      // Third serial transmit
  input  wire logic                  rs232_rx,     // Converter receive
  input  wire logic [1:0]            pin_in,       // Header pin levels
  output bpc_pkg::bpc_pins_type      pins,         // Header pin drive
  output logic                       uart_rx,      // Third serial receive
  output logic                       rs232_tx,     // Converter transmit
  output logic [1:0]                 dio_in        // Pin levels to digital IO
);

  // Register state of the bank apart from the scratch bit
  typedef struct packed {
    bpc_pkg::bpc_phase_type phase;
    logic [6:0]             cfg;
    logic                   ack;
    logic                   err;
    logic [31:0]            rdata;
    logic                   opt;
  } bpc_state_type;

  bpc_state_type s_q;
  bpc_state_type s_d;
  logic          scratch_q;
  logic          scratch_d;

  // Address decode shared by read and write paths
  function automatic logic [1:0] bpc_decode(input logic [31:0] adr);
    if (adr == bpc_pkg::ADDR_POWER_CONFIG)
      return 2'h1;
    else if (adr == bpc_pkg::ADDR_MODEL_CODE)
      return 2'h2;
    else if (adr == bpc_pkg::ADDR_OPTION_FLAGS)
      return 2'h3;
    else
      return 2'h0;
  endfunction

  logic [1:0] sel_reg;
  logic       req;
  logic       wr_cfg;
  logic [7:0] cfg_view;

  assign sel_reg  = bpc_decode(wb_adr_i);
  assign req      = wb_cyc_i && wb_stb_i && !s_q.ack && !s_q.err;
  assign wr_cfg   = req && wb_we_i && wb_sel_i[0] && (sel_reg == 2'h1); // RQ1
  assign cfg_view = {scratch_q, s_q.cfg};

  // Next-state logic; answer comes one cycle after the request is seen
  always_comb
  begin
    s_d     = s_q;
    s_d.ack = 1'b0;
    s_d.err = 1'b0;
    unique case (s_q.phase)
      bpc_pkg::BPC_PH_RESET:
      begin
        s_d.phase = bpc_pkg::BPC_PH_STRAP;
      end
      bpc_pkg::BPC_PH_STRAP:
      begin
        // Straps caught after release, never inside the async reset
        s_d.cfg[bpc_pkg::BIT_SWITCHER_EN] = !switcher_strap_jumper; // RQ4
        s_d.opt   = five_uart_option;                               // RQ14
        s_d.phase = bpc_pkg::BPC_PH_RUN;
      end
      bpc_pkg::BPC_PH_RUN:
      begin
        if (req)
        begin
          s_d.ack = (sel_reg != 2'h0);
          s_d.err = (sel_reg == 2'h0);
          s_d.rdata = 32'h0000_0000;
          unique case (sel_reg)
            2'h1: s_d.rdata[7:0] = cfg_view;                        // RQ1
            2'h2: s_d.rdata[2:0] = MODEL_CODE;                      // RQ13
            2'h3: s_d.rdata[0]   = s_q.opt;                         // RQ15
            2'h0: s_d.rdata      = 32'h0000_0000;
          endcase
        end
        if (wr_cfg)
        begin
          s_d.cfg[2:0] = wb_dat_i[2:0];                             // RQ2
          s_d.cfg[6:4] = wb_dat_i[6:4];                             // RQ6
          if (!switcher_strap_jumper)
            s_d.cfg[bpc_pkg::BIT_SWITCHER_EN] =
              wb_dat_i[bpc_pkg::BIT_SWITCHER_EN];                   // RQ3
        end
      end
      default:
      begin
        s_d.phase = bpc_pkg::BPC_PH_RESET;
      end
    endcase
  end

  // Board reset clears everything except the scratch bit
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      s_q       <= '0;
      s_q.cfg   <= bpc_pkg::POWER_CONFIG_RESET[6:0];
      s_q.phase <= bpc_pkg::BPC_PH_RESET;
    end
    else
      s_q <= s_d;
  end

  // Scratch bit survives board reset; only power-on clears it
  assign scratch_d = (wr_cfg && s_q.phase == bpc_pkg::BPC_PH_RUN) ?
                     wb_dat_i[bpc_pkg::BIT_SCRATCH] : scratch_q;   // RQ11

  always_ff @(posedge clk_sys or posedge por)
  begin
    if (por)
      scratch_q <= bpc_pkg::SCRATCH_POR_VALUE;                      // RQ16
    else
      scratch_q <= scratch_d;                                       // RQ11
  end

  // Bus answers
  assign wb_ack_o = s_q.ack;
  assign wb_err_o = s_q.err;
  assign wb_dat_o = s_q.rdata;

  // Control outputs straight from register bits
  always_comb
  begin
    ctrl.serial_pwr_on = s_q.cfg[bpc_pkg::BIT_SERIAL_PWR];          // RQ2
    ctrl.usb_pwr_on    = s_q.cfg[bpc_pkg::BIT_USB_PWR];             // RQ2
    ctrl.lcd_pwr_on    = s_q.cfg[bpc_pkg::BIT_LCD_PWR];             // RQ2
    ctrl.switcher_on   = s_q.cfg[bpc_pkg::BIT_SWITCHER_EN];         // RQ3
    ctrl.xbus_clk_stop = s_q.cfg[bpc_pkg::BIT_XBUS_CLK_OFF];        // RQ6
    ctrl.fast_strobe   = s_q.cfg[bpc_pkg::BIT_FAST_STROBE];         // RQ7
    ctrl.ttl_route     = s_q.cfg[bpc_pkg::BIT_TTL_ROUTE];           // RQ9
  end

  // Serial routing onto the digital IO header
  bpc_pin_mux u_mux
  (
    .ttl_route (s_q.cfg[bpc_pkg::BIT_TTL_ROUTE]),
    .dio_out   (dio_out),
    .dio_oe_n  (dio_oe_n),
    .uart_tx   (uart_tx),
    .rs232_rx  (rs232_rx),
    .pin_in    (pin_in),
    .pins      (pins),
    .uart_rx   (uart_rx),
    .rs232_tx  (rs232_tx),
    .dio_in    (dio_in)
  );

endmodule

// File: verification/bpc_regs_sva.sv
// Concurrent checks on the power control register block ports
`timescale 1ns/1ns
module bpc_sva
#(
  parameter logic [2:0] MODEL_CODE = 3'h5 // Arbitrary
)
(
  input wire logic                  clk_sys,   // Bus clock
  input wire logic                  rst,       // Board reset
  input wire logic                  switcher_strap_jumper, // Strap
  input wire logic                  five_uart_option, // Option
  input wire logic                  wb_we_i,   // Write
  input wire logic [31:0]           wb_adr_i,  // Address
  input wire logic [3:0]            wb_sel_i,  // Lanes
  input wire logic [31:0]           wb_dat_i,  // Write data
  input wire logic [31:0]           wb_dat_o,  // Read data
  input wire logic                  wb_ack_o,  // Acknowledge
  input wire bpc_pkg::bpc_ctrl_type ctrl,      // Controls
  input wire logic                  uart_tx,   // Serial transmit
  input wire logic [1:0]            pin_in,    // Pin levels
  input wire bpc_pkg::bpc_pins_type pins,      // Pin drive
  input wire logic                  uart_rx    // Serial receive
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  // Controls in register bit order, serial power at bit 0
  logic [6:0] cbits;
  logic       wr_pw;
  logic       rd_ack;
  assign cbits = {<<{ctrl}};
  assign rd_ack = wb_ack_o & ~wb_we_i;
  assign wr_pw = wb_ack_o & wb_we_i & wb_sel_i[0]
    & (wb_adr_i == bpc_pkg::ADDR_POWER_CONFIG);
  // Ack is a single-cycle pulse
  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held");
  // Power register reads back the live controls
  property p_readback;
    rd_ack && wb_adr_i == bpc_pkg::ADDR_POWER_CONFIG
      |-> wb_dat_o[6:0] == cbits;
  endproperty
  a_readback: assert property (p_readback) else $error("readback");
  property p_supply;
    wr_pw |-> cbits[2:0] == wb_dat_i[2:0];
  endproperty
  a_supply: assert property (p_supply) else $error("supply bits");
  // Strap installed freezes the switcher enable
  property p_strap;
    wr_pw |-> cbits[3] ==
      (switcher_strap_jumper ? $past(cbits[3]) : wb_dat_i[3]);
  endproperty
  a_strap: assert property (p_strap) else $error("switcher bit");
  property p_bus_bits;
    wr_pw |-> cbits[6:4] == wb_dat_i[6:4];
  endproperty
  a_bus_bits: assert property (p_bus_bits) else $error("bits 6:4");
  // Routed serial beats digital IO settings
  property p_route;
    ctrl.ttl_route |-> pins.oe_n == 2'h2 && pins.out[0] == uart_tx
      && uart_rx == pin_in[1];
  endproperty
  a_route: assert property (p_route) else $error("ttl route");
  property p_model;
    rd_ack && wb_adr_i == bpc_pkg::ADDR_MODEL_CODE
      |-> wb_dat_o[2:0] == MODEL_CODE;
  endproperty
  a_model: assert property (p_model) else $error("model code");
  property p_option;
    rd_ack && wb_adr_i == bpc_pkg::ADDR_OPTION_FLAGS
      |-> wb_dat_o[0] == five_uart_option;
  endproperty
  a_option: assert property (p_option) else $error("option bit");
endmodule

// File: verification/tb_top.sv
// Directed bench for the power control register block
`timescale 1ns/1ns
module tb_top;
  localparam logic [2:0]  MC = 3'h3; // Arbitrary model code
  localparam logic [31:0] PW = bpc_pkg::ADDR_POWER_CONFIG;
  logic clk_sys, rst, por, switcher_strap_jumper, five_uart_option;
  logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, wb_err_o, er;
  logic [31:0] wb_adr_i, wb_dat_i, wb_dat_o, rd;
  logic [3:0] wb_sel_i;
  logic [1:0] dio_out, dio_oe_n, pin_in, dio_in;
  logic uart_tx, rs232_rx, uart_rx, rs232_tx;
  bpc_pkg::bpc_ctrl_type ctrl;
  bpc_pkg::bpc_pins_type pins;
  int bad_count, comparisons, cyc_n;
  bpc_regs #(.MODEL_CODE(MC)) dut (.clk_sys, .rst, .por,
    .switcher_strap_jumper, .five_uart_option, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
    .wb_err_o, .ctrl, .dio_out, .dio_oe_n, .uart_tx, .rs232_rx, .pin_in,
    .pins, .uart_rx, .rs232_tx, .dio_in);
  // Clock and hang guard, ceiling far above the fewer than a hundred cycles used
  initial
  begin
    clk_sys = 1'h0;
    forever #10 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys)
  begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 3000)
    begin
      bad_count++;
      print_verdict();
    end
  end
  task automatic chk(input logic [31:0] got, exp);
    comparisons++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Classic single cycle; waits for ack or err, releases only after it
  // No local wait limit: only the bench cycle ceiling ends a hang
  task automatic bus(input logic w, input logic [31:0] a, d,
                     input logic [3:0] s = 4'hF);
    @(posedge clk_sys);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= s;
    do
    begin
      @(posedge clk_sys);
    end
    while (wb_ack_o !== 1'h1 && wb_err_o !== 1'h1);
    rd = wb_dat_o;
    er = wb_err_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
  endtask
  task automatic rdchk(input logic [31:0] exp);
    bus(1'h0, PW, 32'h0);
    chk(rd, exp);
  endtask
  // Reset held two cycles, returns two edges after release, first request driven on the third
  task automatic rs(input logic p);
    rst <= 1'h1;
    por <= p;
    repeat (2) @(posedge clk_sys);
    rst <= 1'h0;
    por <= 1'h0;
    repeat (2) @(posedge clk_sys);
  endtask
  task automatic print_verdict;
    $display("bad_count=%0d comparisons=%0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    {rst, por, wb_cyc_i, wb_stb_i, wb_we_i, switcher_strap_jumper} = 6'h30;
    {wb_adr_i, wb_dat_i, wb_sel_i, cyc_n} = '0;
    {five_uart_option, uart_tx, rs232_rx, pin_in} = 5'h1A;
    {dio_out, dio_oe_n} = 4'h4;
    rs(1'h1);
    rdchk(32'h08);
    bus(1'h1, PW, 32'hFF);
    rdchk(32'hFF);
    chk({25'h0, ctrl}, 32'h7F);
    bus(1'h1, PW, 32'h5A);
    chk({25'h0, ctrl}, 32'h2D);
    bus(1'h1, PW, 32'hA5, 4'hE);
    rdchk(32'h5A);
    @(negedge clk_sys);
    chk({pins.out[0], pins.oe_n, uart_rx, rs232_tx}, 32'h1B);
    bus(1'h1, PW, 32'h00);
    @(negedge clk_sys);
    chk({pins, uart_rx, rs232_tx}, 32'h11);
    chk({30'h0, dio_in}, 32'h2);
    bus(1'h1, bpc_pkg::ADDR_MODEL_CODE, 32'hFF);
    bus(1'h0, bpc_pkg::ADDR_MODEL_CODE, 32'h0);
    chk(rd[2:0], MC);
    bus(1'h0, bpc_pkg::ADDR_OPTION_FLAGS, 32'h0);
    chk(rd[0], 1'h1);
    bus(1'h0, 32'h1200_0010, 32'h0);
    chk(er, 1'h1);
    bus(1'h1, PW, 32'h88);
    switcher_strap_jumper <= 1'h1;
    five_uart_option <= 1'h0;
    rs(1'h0);
    rdchk(32'h80);
    bus(1'h1, PW, 32'h8F);
    rdchk(32'h87);
    bus(1'h0, bpc_pkg::ADDR_OPTION_FLAGS, 32'h0);
    chk(rd[0], 1'h0);
    switcher_strap_jumper <= 1'h0;
    rs(1'h1);
    rdchk(32'h08);
    print_verdict();
  end
endmodule
bind bpc_regs bpc_sva #(.MODEL_CODE(MODEL_CODE)) u_sva (.clk_sys, .rst,
  .switcher_strap_jumper, .five_uart_option, .wb_we_i, .wb_adr_i,
  .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .ctrl, .uart_tx, .pin_in,
  .pins, .uart_rx);
